// ==== design/wacc_pkg.sv ====
package wacc_pkg;

    localparam int WORD_W    = 16;
    localparam int BIT_IDX_W = 4;
    localparam int NUM_BANKS = 3;

    // Status bit positions written by a compare
    localparam int CMP_LT_BIT = 1;
    localparam int CMP_EQ_BIT = 2;
    localparam int CMP_GT_BIT = 3;

    // Bit of the tracking word that holds the previous bit accumulator
    localparam int TRACK_BIT = 0;

    localparam logic [WORD_W-1:0] WORD_ACC_RST = 16'h0000;
    localparam logic              BIT_ACC_RST  = 1'b0;
    localparam logic [WORD_W-1:0] BANK_RST     = 16'h0000;

    // Operand source or store target
    typedef enum logic [1:0] {
        SP_CONST   = 2'b00,
        SP_NORMAL  = 2'b01,
        SP_SCRATCH = 2'b10,
        SP_PERSIST = 2'b11
    } wacc_space_type;

    typedef enum logic [3:0] {
        OP_LOAD         = 4'h0,
        OP_COMPARE      = 4'h1,
        OP_CONJ         = 4'h2,
        OP_DISJ         = 4'h3,
        OP_EXDISJ       = 4'h4,
        OP_EDGE_STORE   = 4'h5,
        OP_BIT_LOAD     = 4'h6,
        OP_BIT_LOAD_NOT = 4'h7,
        OP_BIT_CONJ     = 4'h8,
        OP_BIT_CONJ_NOT = 4'h9,
        OP_BIT_DISJ     = 4'ha,
        OP_BIT_DISJ_NOT = 4'hb
    } wacc_op_type;

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_TRACK = 1'b1
    } wacc_fsm_type;

endpackage

// ==== design/wacc_regfile.sv ====
`timescale 1ns/1ps
module wacc_regfile
    import wacc_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 wr_en,
    input  wire wacc_space_type       wr_space,
    input  wire logic [ADDR_W-1:0]    wr_addr,
    input  wire logic [WORD_W-1:0]    wr_data,
    input  wire wacc_space_type       opd_space,
    input  wire logic [ADDR_W-1:0]    opd_addr,
    output logic      [WORD_W-1:0]    opd_data,
    input  wire logic [ADDR_W-1:0]    trk_addr,
    output logic      [WORD_W-1:0]    trk_data,
    input  wire wacc_space_type       dbg_space,
    input  wire logic [ADDR_W-1:0]    dbg_addr,
    output logic      [WORD_W-1:0]    dbg_data
);

    localparam int DEPTH = 1 << ADDR_W;

    typedef struct packed {
        logic [NUM_BANKS-1:0][DEPTH-1:0][WORD_W-1:0] banks;
    } wacc_bank_type;

    wacc_bank_type mem_q;
    wacc_bank_type mem_d;

    // Constant space has no storage; reads give zero and writes are dropped
    function automatic logic [WORD_W-1:0] bank_read(
        input wacc_bank_type     m,
        input wacc_space_type    sp,
        input logic [ADDR_W-1:0] a
    );
        logic [WORD_W-1:0] v;
        v = '0;
        case (sp)
            SP_NORMAL:  v = m.banks[0][a];
            SP_SCRATCH: v = m.banks[1][a];
            SP_PERSIST: v = m.banks[2][a];
            default:    v = '0;
        endcase
        return v;
    endfunction

    always_comb begin
        mem_d = mem_q;
        if (wr_en) begin
            case (wr_space)
                SP_NORMAL:  mem_d.banks[0][wr_addr] = wr_data;
                SP_SCRATCH: mem_d.banks[1][wr_addr] = wr_data;
                SP_PERSIST: mem_d.banks[2][wr_addr] = wr_data;
                default:    mem_d = mem_q;
            endcase
        end
    end

    assign opd_data = bank_read(mem_q, opd_space, opd_addr);
    assign trk_data = bank_read(mem_q, SP_SCRATCH, trk_addr);
    assign dbg_data = bank_read(mem_q, dbg_space, dbg_addr);

    // Retention of the persistent bank over power loss is outside this model
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_q <= {NUM_BANKS * DEPTH{BANK_RST}};
        end else begin
            mem_q <= mem_d;
        end
    end

endmodule

// ==== design/wacc_core.sv ====
// Notes on behaviour
// - Constant load puts the 16-bit immediate into the word accumulator.
// - Register load copies a normal, scratch or persistent word into the accumulator.
// - Compare takes any operand source; results go to scratch word named by arg2.
// - Compare sets status bit 1 when accumulator is unsigned-less than operand.
// - Compare sets status bit 2 when accumulator equals operand.
// - Compare sets status bit 3 when accumulator is greater than operand.
// - Constant AND uses a 0 or 1 immediate against the accumulator.
// - Register AND combines the addressed word into the accumulator.
// - Constant OR uses a 0 or 1 immediate against the accumulator.
// - Register OR combines the addressed normal, scratch or persistent word by inclusive OR.
// - Constant XOR uses a full 16-bit immediate against the accumulator.
// - Register XOR combines the addressed word into the accumulator.
// - Edge store writes the accumulator to arg1 only on a bit accumulator rise.
// - Bit commands load or combine one addressed bit into the bit accumulator.
`timescale 1ns/1ps
module wacc_core
    import wacc_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 cmd_valid,
    input  wire wacc_op_type          cmd_op,
    input  wire wacc_space_type       cmd_space,
    input  wire logic [WORD_W-1:0]    cmd_arg1,
    input  wire logic [WORD_W-1:0]    cmd_arg2,
    output logic                      cmd_ready,
    output logic                      cmd_done,
    output logic                      store_fired,
    output logic      [WORD_W-1:0]    word_acc,
    output logic                      bit_acc,
    output logic      [WORD_W-1:0]    cmp_word,
    input  wire wacc_space_type       rd_space,
    input  wire logic [ADDR_W-1:0]    rd_addr,
    output logic      [WORD_W-1:0]    rd_data
);

    typedef struct packed {
        wacc_fsm_type      fsm;
        logic              ready;
        logic              done;
        logic              fired;
        logic [WORD_W-1:0] word_acc;
        logic              bit_acc;
        logic [WORD_W-1:0] cmp_word;
        logic [ADDR_W-1:0] track_addr;
        logic [WORD_W-1:0] rd_data;
    } wacc_state_type;

    wacc_state_type st_q;
    wacc_state_type st_d;

    logic              accept;
    logic              wr_en;
    wacc_space_type    wr_space;
    logic [ADDR_W-1:0] wr_addr;
    logic [WORD_W-1:0] wr_data;
    logic [ADDR_W-1:0] trk_addr;
    logic [WORD_W-1:0] opd_data;
    logic [WORD_W-1:0] trk_data;
    logic [WORD_W-1:0] dbg_data;
    logic [WORD_W-1:0] opnd;
    logic [WORD_W-1:0] cmp_calc;
    logic              bit_sel;
    logic              rising;

    wacc_regfile #(
        .ADDR_W    (ADDR_W)
    ) u_regfile (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .wr_en     (wr_en),
        .wr_space  (wr_space),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .opd_space (cmd_space),
        .opd_addr  (cmd_arg1[ADDR_W-1:0]),
        .opd_data  (opd_data),
        .trk_addr  (trk_addr),
        .trk_data  (trk_data),
        .dbg_space (rd_space),
        .dbg_addr  (rd_addr),
        .dbg_data  (dbg_data)
    );

    assign accept = cmd_valid && st_q.ready;

    // Logic immediates keep only bit 0; load, compare and XOR take all 16 bits
    always_comb begin
        if (cmd_space != SP_CONST) begin
            opnd = opd_data;
        end else if (cmd_op == OP_CONJ || cmd_op == OP_DISJ) begin
            opnd = {{(WORD_W-1){1'b0}}, cmd_arg1[0]};
        end else begin
            opnd = cmd_arg1;
        end
    end

    always_comb begin
        cmp_calc = '0;
        cmp_calc[CMP_LT_BIT] = st_q.word_acc < opnd;
        cmp_calc[CMP_EQ_BIT] = st_q.word_acc == opnd;
        cmp_calc[CMP_GT_BIT] = st_q.word_acc > opnd;
    end

    assign bit_sel = opnd[cmd_arg2[BIT_IDX_W-1:0]];
    assign rising  = !trk_data[TRACK_BIT] && st_q.bit_acc;

    always_comb begin
        st_d         = st_q;
        st_d.done    = 1'b0;
        st_d.fired   = 1'b0;
        st_d.rd_data = dbg_data;
        wr_en        = 1'b0;
        wr_space     = cmd_space;
        wr_addr      = cmd_arg1[ADDR_W-1:0];
        wr_data      = st_q.word_acc;
        trk_addr     = cmd_arg2[ADDR_W-1:0];
        case (st_q.fsm)
            ST_IDLE: begin
                st_d.ready = 1'b1;
                if (accept) begin
                    st_d.done = 1'b1;
                    case (cmd_op)
                        OP_LOAD: begin
                            st_d.word_acc = opnd;
                        end
                        OP_COMPARE: begin
                            wr_en         = 1'b1;
                            wr_space      = SP_SCRATCH;
                            wr_addr       = cmd_arg2[ADDR_W-1:0];
                            wr_data       = cmp_calc;
                            st_d.cmp_word = cmp_calc;
                        end
                        OP_CONJ: begin
                            st_d.word_acc = st_q.word_acc & opnd;
                        end
                        OP_DISJ: begin
                            // Persistent operands also take inclusive OR here
                            st_d.word_acc = st_q.word_acc | opnd;
                        end
                        OP_EXDISJ: begin
                            st_d.word_acc = st_q.word_acc ^ opnd;
                        end
                        OP_EDGE_STORE: begin
                            // Target write now, tracking word next cycle: one write port
                            // Constant space has no storage, so nothing is reported stored
                            wr_en           = rising && cmd_space != SP_CONST;
                            st_d.fired      = rising && cmd_space != SP_CONST;
                            st_d.fsm        = ST_TRACK;
                            st_d.ready      = 1'b0;
                            st_d.done       = 1'b0;
                            st_d.track_addr = cmd_arg2[ADDR_W-1:0];
                        end
                        OP_BIT_LOAD: begin
                            st_d.bit_acc = bit_sel;
                        end
                        OP_BIT_LOAD_NOT: begin
                            st_d.bit_acc = !bit_sel;
                        end
                        OP_BIT_CONJ: begin
                            st_d.bit_acc = st_q.bit_acc && bit_sel;
                        end
                        OP_BIT_CONJ_NOT: begin
                            st_d.bit_acc = st_q.bit_acc && !bit_sel;
                        end
                        OP_BIT_DISJ: begin
                            st_d.bit_acc = st_q.bit_acc || bit_sel;
                        end
                        OP_BIT_DISJ_NOT: begin
                            st_d.bit_acc = st_q.bit_acc || !bit_sel;
                        end
                        default: begin
                            st_d.done = 1'b1;
                        end
                    endcase
                end
            end
            ST_TRACK: begin
                // Other bits of the tracking word are kept for the program's use
                trk_addr   = st_q.track_addr;
                wr_en      = 1'b1;
                wr_space   = SP_SCRATCH;
                wr_addr    = st_q.track_addr;
                wr_data    = {trk_data[WORD_W-1:1], st_q.bit_acc};
                st_d.fsm   = ST_IDLE;
                st_d.ready = 1'b1;
                st_d.done  = 1'b1;
            end
            default: begin
                st_d.fsm   = ST_IDLE;
                st_d.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_q.fsm        <= ST_IDLE;
            st_q.ready      <= 1'b1;
            st_q.done       <= 1'b0;
            st_q.fired      <= 1'b0;
            st_q.word_acc   <= WORD_ACC_RST;
            st_q.bit_acc    <= BIT_ACC_RST;
            st_q.cmp_word   <= '0;
            st_q.track_addr <= '0;
            st_q.rd_data    <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign cmd_ready   = st_q.ready;
    assign cmd_done    = st_q.done;
    assign store_fired = st_q.fired;
    assign word_acc    = st_q.word_acc;
    assign bit_acc     = st_q.bit_acc;
    assign cmp_word    = st_q.cmp_word;
    assign rd_data     = st_q.rd_data;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_const_load: assert property (
        accept && cmd_op == OP_LOAD && cmd_space == SP_CONST
        |=> word_acc == $past(cmd_arg1) && cmd_done
    ) else $error("constant load did not reach the word accumulator");

    a_reg_load: assert property (
        accept && cmd_op == OP_LOAD && cmd_space != SP_CONST
        |=> word_acc == $past(opd_data)
    ) else $error("register load did not copy the addressed word");

    a_cmp_write: assert property (
        accept && cmd_op == OP_COMPARE
        |-> wr_en && wr_space == SP_SCRATCH && wr_addr == cmd_arg2[ADDR_W-1:0]
    ) else $error("compare result not written to the named scratch word");

    a_cmp_less: assert property (
        accept && cmd_op == OP_COMPARE
        |=> cmp_word[CMP_LT_BIT] == ($past(word_acc) < $past(opnd))
    ) else $error("compare less-than bit wrong");

    a_cmp_equal: assert property (
        accept && cmd_op == OP_COMPARE
        |=> cmp_word[CMP_EQ_BIT] == ($past(word_acc) == $past(opnd))
    ) else $error("compare equal bit wrong");

    a_cmp_greater: assert property (
        accept && cmd_op == OP_COMPARE
        |=> cmp_word[CMP_GT_BIT] == ($past(word_acc) > $past(opnd))
            && $countones(cmp_word) == 1
    ) else $error("compare greater-than bit wrong");

    a_conj_const: assert property (
        accept && cmd_op == OP_CONJ && cmd_space == SP_CONST
        |=> word_acc == ($past(word_acc) & {{(WORD_W-1){1'b0}}, $past(cmd_arg1[0])})
    ) else $error("constant AND result wrong");

    a_conj_reg: assert property (
        accept && cmd_op == OP_CONJ && cmd_space != SP_CONST
        |=> word_acc == ($past(word_acc) & $past(opd_data))
    ) else $error("register AND result wrong");

    a_disj_const: assert property (
        accept && cmd_op == OP_DISJ && cmd_space == SP_CONST
        |=> word_acc == ($past(word_acc) | {{(WORD_W-1){1'b0}}, $past(cmd_arg1[0])})
    ) else $error("constant OR result wrong");

    a_disj_reg: assert property (
        accept && cmd_op == OP_DISJ && cmd_space != SP_CONST
        |=> word_acc == ($past(word_acc) | $past(opd_data))
    ) else $error("register OR result wrong");

    a_exdisj_any: assert property (
        accept && cmd_op == OP_EXDISJ
        |=> word_acc == ($past(word_acc) ^ $past(opnd))
    ) else $error("XOR result wrong");

    a_edge_store: assert property (
        accept && cmd_op == OP_EDGE_STORE
        |-> (wr_en == (!trk_data[TRACK_BIT] && bit_acc && cmd_space != SP_CONST))
            && wr_data == word_acc
            ##1 store_fired == $past(wr_en) && !cmd_ready ##1 cmd_done && cmd_ready
    ) else $error("edge store fired without a rising bit accumulator");

    a_bit_load: assert property (
        accept && (cmd_op == OP_BIT_LOAD || cmd_op == OP_BIT_LOAD_NOT)
        |=> bit_acc == ($past(bit_sel) ^ $past(cmd_op == OP_BIT_LOAD_NOT))
    ) else $error("bit load gave the wrong bit accumulator");

    a_track_word: assert property (
        accept && cmd_op == OP_EDGE_STORE
        |=> wr_en && wr_space == SP_SCRATCH
            && wr_addr == $past(cmd_arg2[ADDR_W-1:0])
            && wr_data[TRACK_BIT] == $past(bit_acc)
    ) else $error("previous bit accumulator not tracked");

endmodule

// ==== test/wacc_seq_model.sv ====
`timescale 1ns/1ps
module wacc_seq_model
    import wacc_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 cmd_ready,
    input  wire logic                 cmd_done,
    input  wire logic                 store_fired,
    output logic                      cmd_valid,
    output wacc_op_type               cmd_op,
    output wacc_space_type            cmd_space,
    output logic      [WORD_W-1:0]    cmd_arg1,
    output logic      [WORD_W-1:0]    cmd_arg2
);
    localparam int DRV = 1;
    initial begin
        cmd_valid = 1'b0;
        cmd_op    = OP_LOAD;
        cmd_space = SP_CONST;
        cmd_arg1  = 16'h0000;
        cmd_arg2  = 16'h0000;
    end
    // Entered just after a rising edge; request held until the edge that takes it
    task automatic issue(input wacc_op_type op, input wacc_space_type sp,
                         input logic [WORD_W-1:0] a1, input logic [WORD_W-1:0] a2,
                         input int stall, output logic fired, output logic dip,
                         output logic hung);
        int n;
        fired = 1'b0;
        dip   = 1'b0;
        hung  = 1'b0;
        repeat (stall) begin
            @(posedge ref_clk);
            #DRV;
        end
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_space = sp;
        cmd_arg1  = a1;
        cmd_arg2  = a2;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #DRV;
            n++;
        end
        @(posedge ref_clk);
        #DRV;
        // Released lines show a changed pattern so stale values never look valid
        cmd_valid = 1'b0;
        cmd_op    = wacc_op_type'(~cmd_op);
        cmd_space = wacc_space_type'(~cmd_space);
        cmd_arg1  = ~cmd_arg1;
        cmd_arg2  = ~cmd_arg2;
        while (cmd_done !== 1'b1 && n < 16) begin
            fired = fired | (store_fired === 1'b1);
            dip   = dip | (cmd_ready === 1'b0);
            @(posedge ref_clk);
            #DRV;
            n++;
        end
        fired = fired | (store_fired === 1'b1);
        hung  = (n >= 16);
        // Released lines stand over one edge before the next request may raise them
        @(posedge ref_clk);
        #DRV;
    endtask
endmodule

// ==== test/word_accumulator_logic_unit_tb_top.sv ====
`timescale 1ns/1ps
module word_accumulator_logic_unit_tb_top;
    import wacc_pkg::*;
    localparam logic [15:0]    CACC [6] = '{16'h0005, 16'h0005, 16'h0005, 16'h8000,
                                            16'h0000, 16'hffff};
    localparam logic [15:0]    COPV [6] = '{16'h0006, 16'h0005, 16'h0004, 16'h7fff,
                                            16'hffff, 16'hffff};
    localparam wacc_space_type CSP  [6] = '{SP_CONST, SP_NORMAL, SP_SCRATCH, SP_PERSIST,
                                            SP_CONST, SP_SCRATCH};
    logic ref_clk = 1'b0;
    logic resetn  = 1'b0;
    logic cmd_valid, cmd_ready, cmd_done, store_fired, bit_acc;
    wacc_op_type    cmd_op;
    wacc_space_type cmd_space;
    wacc_space_type rd_space = SP_NORMAL;
    logic [3:0]  rd_addr = 4'h0;
    logic [15:0] cmd_arg1, cmd_arg2, word_acc, cmp_word, rd_data, rv;
    logic        fired, dip, hung;
    int          mismatches = 0;
    int          check_count = 0;

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    wacc_core #(.ADDR_W(4)) i_dut (.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_space(cmd_space), .cmd_arg1(cmd_arg1), .cmd_arg2(cmd_arg2),
        .cmd_ready(cmd_ready), .cmd_done(cmd_done), .store_fired(store_fired),
        .word_acc(word_acc), .bit_acc(bit_acc), .cmp_word(cmp_word), .rd_space(rd_space),
        .rd_addr(rd_addr), .rd_data(rd_data));

    wacc_seq_model i_seq (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
        .store_fired(store_fired), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_space(cmd_space), .cmd_arg1(cmd_arg1), .cmd_arg2(cmd_arg2));

    task automatic stop_test();
        $display("mismatches %0d check_count %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    task automatic cmd(input wacc_op_type op, input wacc_space_type sp,
                       input logic [15:0] a1, input logic [15:0] a2, input int stall = 0);
        i_seq.issue(op, sp, a1, a2, stall, fired, dip, hung);
        if (hung) begin
            $display("unexpected command completion: expected done seen none");
            mismatches++;
            stop_test();
        end
    endtask

    task automatic rd(input wacc_space_type sp, input logic [3:0] a);
        rd_space = sp;
        rd_addr  = a;
        @(posedge ref_clk);
        #1;
        rv = rd_data;
    endtask

    // Scratch word 15 is reserved as the tracking word of this helper
    task automatic poke(input wacc_space_type sp, input logic [3:0] a, input logic [15:0] v);
        cmd(OP_LOAD, SP_CONST, v, 16'h0000);
        cmd(OP_BIT_LOAD, SP_CONST, 16'h0000, 16'h0000);
        cmd(OP_EDGE_STORE, sp, {12'h000, a}, 16'h000f);
        cmd(OP_BIT_LOAD, SP_CONST, 16'h0001, 16'h0000);
        cmd(OP_EDGE_STORE, sp, {12'h000, a}, 16'h000f);
    endtask

    task automatic t_load();
        cmd(OP_LOAD, SP_CONST, 16'hffff, 16'h0000, 3);
        check("const load max", 16'hffff, word_acc);
        cmd(OP_LOAD, SP_CONST, 16'h0000, 16'h0000);
        check("const load zero", 16'h0000, word_acc);
        poke(SP_NORMAL, 4'h2, 16'ha5a5);
        poke(SP_SCRATCH, 4'h2, 16'h3c3c);
        poke(SP_PERSIST, 4'h2, 16'h0ff0);
        cmd(OP_LOAD, SP_NORMAL, 16'h0002, 16'h0000);
        check("normal load", 16'ha5a5, word_acc);
        cmd(OP_LOAD, SP_SCRATCH, 16'h0002, 16'h0000);
        check("scratch load", 16'h3c3c, word_acc);
        cmd(OP_LOAD, SP_PERSIST, 16'h0002, 16'h0000);
        check("persistent load", 16'h0ff0, word_acc);
    endtask

    task automatic t_compare();
        logic [15:0] e;
        for (int i = 0; i < 6; i++) begin
            if (CSP[i] != SP_CONST) poke(CSP[i], 4'h4, COPV[i]);
            cmd(OP_LOAD, SP_CONST, CACC[i], 16'h0000);
            e = {12'h000, CACC[i] > COPV[i], CACC[i] == COPV[i], CACC[i] < COPV[i], 1'b0};
            cmd(OP_COMPARE, CSP[i], (CSP[i] == SP_CONST) ? COPV[i] : 16'h0004, 16'(5 + i));
            check("compare status", e, cmp_word);
            rd(SP_SCRATCH, 4'(5 + i));
            check("compare result word", e, rv);
        end
    endtask

    task automatic t_logic();
        wacc_op_type    op;
        logic [15:0]    b, a1, opv, e;
        poke(SP_NORMAL, 4'h1, 16'h0ff1);
        poke(SP_SCRATCH, 4'h1, 16'h0ff1);
        poke(SP_PERSIST, 4'h1, 16'h0ff1);
        for (int k = 0; k < 3; k++) begin
            op = (k == 0) ? OP_CONJ : (k == 1) ? OP_DISJ : OP_EXDISJ;
            // Base with bit 0 clear for OR so a constant 1 really changes the result
            b  = (op == OP_DISJ) ? 16'h3c96 : 16'h3c97;
            for (int s = 0; s < 4; s++) begin
                a1  = (s != 0) ? 16'h0001 : (op == OP_EXDISJ) ? 16'hf00f : 16'h0001;
                opv = (s == 0) ? a1 : 16'h0ff1;
                e   = (k == 0) ? (b & opv) : (k == 1) ? (b | opv) : (b ^ opv);
                cmd(OP_LOAD, SP_CONST, b, 16'h0000);
                cmd(op, wacc_space_type'(s), a1, 16'h0000);
                check("logic result", e, word_acc);
            end
        end
    endtask

    task automatic t_bits();
        wacc_op_type ops [6] = '{OP_BIT_LOAD, OP_BIT_LOAD_NOT, OP_BIT_DISJ, OP_BIT_CONJ_NOT,
                                 OP_BIT_DISJ_NOT, OP_BIT_CONJ};
        logic [3:0]  idx [6] = '{4'h2, 4'h2, 4'h2, 4'h2, 4'h0, 4'h0};
        logic        e   [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++) begin
            cmd(ops[i], SP_CONST, 16'h0004, {12'h000, idx[i]});
            check("bit accumulator", {15'h0000, e[i]}, {15'h0000, bit_acc});
        end
        poke(SP_PERSIST, 4'h6, 16'h8000);
        cmd(OP_BIT_LOAD, SP_CONST, 16'h0000, 16'h0000);
        cmd(OP_BIT_LOAD, SP_PERSIST, 16'h0006, 16'h000f);
        check("bit from register", 16'h0001, {15'h0000, bit_acc});
    endtask

    task automatic t_edge();
        poke(SP_SCRATCH, 4'h8, 16'h00a0);
        cmd(OP_LOAD, SP_CONST, 16'hbeef, 16'h0000);
        cmd(OP_BIT_LOAD, SP_CONST, 16'h0001, 16'h0000);
        cmd(OP_EDGE_STORE, SP_NORMAL, 16'h0009, 16'h0008);
        check("store on rise", 16'h0003, {14'h0000, fired, dip});
        rd(SP_NORMAL, 4'h9);
        check("stored word", 16'hbeef, rv);
        rd(SP_SCRATCH, 4'h8);
        check("tracking word set", 16'h00a1, rv);
        cmd(OP_LOAD, SP_CONST, 16'h1234, 16'h0000);
        cmd(OP_EDGE_STORE, SP_NORMAL, 16'h0009, 16'h0008);
        check("no store on level", 16'h0000, {15'h0000, fired});
        rd(SP_NORMAL, 4'h9);
        check("word kept", 16'hbeef, rv);
        cmd(OP_BIT_LOAD, SP_CONST, 16'h0000, 16'h0000);
        cmd(OP_EDGE_STORE, SP_PERSIST, 16'h0009, 16'h0008);
        rd(SP_SCRATCH, 4'h8);
        check("tracking word clear", 16'h00a0, rv);
        cmd(OP_BIT_LOAD, SP_CONST, 16'h0001, 16'h0000);
        cmd(OP_EDGE_STORE, SP_PERSIST, 16'h0009, 16'h0008);
        rd(SP_PERSIST, 4'h9);
        check("persistent store", 16'h1234, rv);
        cmd(OP_EDGE_STORE, SP_CONST, 16'h0009, 16'h000c);
        check("no store to constant", 16'h0001, {14'h0000, fired, dip});
        rd(SP_SCRATCH, 4'hc);
        check("tracking after constant", 16'h0001, rv);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        check("reset word acc", 16'h0000, word_acc);
        check("reset status", 16'h0001, {13'h0000, bit_acc, cmd_done, cmd_ready});
        check("reset compare", 16'h0000, cmp_word);
        resetn = 1'b1;
        t_load();
        t_compare();
        t_logic();
        t_bits();
        t_edge();
        stop_test();
    end
endmodule
